// *** hdl/pcrf_defines.vh ***
// Register offsets, field layouts, reset values and sizes for the partition control bank.
`ifndef PCRF_DEFINES_VH
`define PCRF_DEFINES_VH
// Byte offsets of the control registers.
`define PCRF_OFF_PART_SEL 6'h00
`define PCRF_OFF_CPBM 6'h04
`define PCRF_OFF_CMAX 6'h08
`define PCRF_OFF_MBW_PBM 6'h0c
`define PCRF_OFF_MBW_MAX 6'h10
`define PCRF_OFF_MBW_MIN 6'h14
`define PCRF_OFF_MBW_PROP 6'h18
`define PCRF_OFF_CASSOC 6'h1c
`define PCRF_OFF_EN_FLAGS 6'h20
`define PCRF_OFF_INTPART 6'h24
`define PCRF_OFF_WORK 6'h28
// Partition select field layout.
`define PCRF_SEL_PART_LSB 0
`define PCRF_SEL_NS_BIT 8
// Fraction encoding: 16-bit format, implemented width kept.
`define PCRF_FRAC_FULL 16
`define PCRF_FRAC_W 12
`define PCRF_FRAC_ONES 16'hffff
// Flag positions in the limit registers.
`define PCRF_CMAX_SOFT_BIT 31
`define PCRF_MBW_HARD_BIT 31
`define PCRF_PROP_EN_BIT 31
// Reset values for the default partition.
`define PCRF_PBM_ONES 32'hffffffff
`define PCRF_PROP_RST 1'b0
`define PCRF_FLAG_RST 1'b0
`define PCRF_EN0_RST 1'b1
`define PCRF_DEF_PART 4'h0
// Sizes: partitions per space and entries across both security spaces.
`define PCRF_NPART 16
`define PCRF_NENT 32
`endif

// *** hdl/pcrf_bank.v ***
// Per-partition control settings bank with reset defaults and fractions.
// Functional notes
// - Reset loads partition 0 fraction limits as all ones in both spaces.
// - Reset sets partition 0 portion bitmaps to all ones in both spaces.
// - Reset clears soft, hard and stride flags; sets enable flag zero for partition 0 only.
// - Request partition 0 maps to internal 0, which receives the defaults.
// - Fractions are 16-bit unsigned fixed point, top bit weighs one half.
// - Unimplemented low fraction bits read as zero and ignore writes.
// - Full 16-bit writes are accepted; low unimplemented bits discarded.
// - Stored v means the range v to v plus 2^-w minus 2^-16.
// - Maximum fractions take the top of range; minimums take the bottom.
// - Only the default partition array settings are reset; the flags reset for all.
`timescale 1ns/1ns
`include "pcrf_defines.vh"
module pcrf_bank (
    input wire clock,
    input wire resetn,
    input wire [5:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    output reg avs_response_error
);
    localparam FW = `PCRF_FRAC_W;
    localparam LOWW = `PCRF_FRAC_FULL - FW;
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_ANSWER = 2'b10;

    // Storage for every partition in both spaces; index is {ns, partition}.
    reg [31:0] cpbm [0:`PCRF_NENT-1];
    reg [31:0] mbw_pbm [0:`PCRF_NENT-1];
    reg [FW-1:0] cmax [0:`PCRF_NENT-1];
    reg [FW-1:0] mbw_max [0:`PCRF_NENT-1];
    reg [FW-1:0] mbw_min [0:`PCRF_NENT-1];
    reg [FW-1:0] cassoc [0:`PCRF_NENT-1];
    reg [`PCRF_NENT-1:0] soft_lim;
    reg [`PCRF_NENT-1:0] hard_lim;
    reg [`PCRF_NENT-1:0] prop_en;
    reg [`PCRF_NENT-1:0] en0;
    reg [15:0] prop_stride [0:`PCRF_NENT-1];
    reg [3:0] int_map [0:`PCRF_NENT-1];
    reg [8:0] part_sel;
    reg [5:0] work_sel;
    // Bus handshake state, one-hot: waiting for a request, or answering.
    reg [1:0] hs_state;
    reg [1:0] next_hs_state;
    reg [31:0] next_rdata;
    reg next_err;
    integer i;

    // Fractions are kept at the implemented width only. Software always
    // writes the full 16-bit code and need not know how many bits survive;
    // the dropped low bits read back as zero. The price is an uncertainty:
    // a stored code v may stand for anything from v up to just below the
    // next code, so each user of a fraction picks the end that is safe for
    // it. Limits must never fall below what software asked for, and
    // guarantees must never promise more than the hardware can give.

    // Widen a stored fraction to the 16-bit format with zero low bits.
    function [15:0] frac_read;
        input [FW-1:0] v;
        begin
            frac_read = {v, {LOWW{1'b0}}};
        end
    endfunction

    // Upper end of the uncertainty range: fill dropped bits with ones.
    function [15:0] frac_top;
        input [FW-1:0] v;
        begin
            frac_top = {v, {LOWW{1'b1}}};
        end
    endfunction

    // Pack a flag and a stored fraction into the register word layout.
    function [31:0] frac_reg;
        input flag;
        input [FW-1:0] v;
        begin
            frac_reg = {flag, 15'h0000, frac_read(v)};
        end
    endfunction

    // Entry addressed by the select register, as {space flag, partition}.
    wire [4:0] ent = {part_sel[`PCRF_SEL_NS_BIT], part_sel[3:0]};
    // The working view goes through the request-to-internal map, so the
    // inspected values are those a request of that partition would use.
    // The setting registers take the select value directly as the internal
    // partition; that keeps software's view of the settings simple.
    wire [4:0] went = {work_sel[4], int_map[work_sel[4:0]]};
    // Keep only the implemented upper bits of a 16-bit write.
    wire [FW-1:0] wfrac = avs_writedata[15:LOWW];

    // Register map, word aligned, offsets in the defines header: select
    // (partition in bits 3:0, space flag in bit 8), cache portion bitmap,
    // cache capacity maximum with the soft-limit flag in bit 31, bandwidth
    // portion bitmap, bandwidth maximum with the hard-limit flag in bit 31,
    // bandwidth minimum, proportional stride with its enable in bit 31,
    // cache associativity limit, enable flag zero in bit 0, the request to
    // internal partition map, and the working view. Any other offset is
    // refused: reads return zero, writes are dropped, the error flag rises.

    // Read mux. The working-value view exposes what the regulators would use:
    // maximum limits at the range top, minimum at the range bottom.
    always @* begin
        next_rdata = 32'h00000000;
        next_err = 1'b0;
        case (avs_address)
            `PCRF_OFF_PART_SEL: next_rdata = {23'h000000, part_sel};
            `PCRF_OFF_CPBM: next_rdata = cpbm[ent];
            `PCRF_OFF_CMAX: next_rdata = frac_reg(soft_lim[ent], cmax[ent]);
            `PCRF_OFF_MBW_PBM: next_rdata = mbw_pbm[ent];
            `PCRF_OFF_MBW_MAX:
                next_rdata = frac_reg(hard_lim[ent], mbw_max[ent]);
            `PCRF_OFF_MBW_MIN: next_rdata = frac_reg(1'b0, mbw_min[ent]);
            `PCRF_OFF_MBW_PROP: next_rdata = {prop_en[ent], 15'h0000,
                prop_stride[ent]};
            `PCRF_OFF_CASSOC: next_rdata = frac_reg(1'b0, cassoc[ent]);
            `PCRF_OFF_EN_FLAGS: next_rdata = {31'h00000000, en0[ent]};
            `PCRF_OFF_INTPART: next_rdata = {28'h0000000, int_map[ent]};
            // Max at top, min at bottom, so a 16-bit share over 65536 is safe.
            `PCRF_OFF_WORK: next_rdata = {frac_top(mbw_max[went]),
                frac_read(mbw_min[went])};
            default: next_err = 1'b1;
        endcase
    end

    // Reset loads the array settings of the default partition of both spaces only;
    // the others hold whatever they had, which saves reset wiring on the arrays;
    // the flag vectors clear for every entry but enable flag zero of the default partition, which is set.
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            part_sel <= 9'h000;
            work_sel <= 6'h00;
            soft_lim <= {`PCRF_NENT{1'b0}};
            hard_lim <= {`PCRF_NENT{1'b0}};
            prop_en <= {`PCRF_NENT{1'b0}};
            en0 <= {`PCRF_NENT{1'b0}};
            for (i = 0; i < `PCRF_NENT; i = i + 1) begin
                if (i % `PCRF_NPART == 0) begin
                    cpbm[i] <= `PCRF_PBM_ONES;
                    mbw_pbm[i] <= `PCRF_PBM_ONES;
                    cmax[i] <= {FW{1'b1}};
                    mbw_max[i] <= {FW{1'b1}};
                    mbw_min[i] <= {FW{1'b1}};
                    cassoc[i] <= {FW{1'b1}};
                    prop_stride[i] <= 16'h0000;
                    int_map[i] <= `PCRF_DEF_PART;
                end
            end
            // Enable flag zero starts set for the default partition only.
            en0[0] <= `PCRF_EN0_RST;
            en0[`PCRF_NPART] <= `PCRF_EN0_RST;
        end else if (avs_write && hs_state == ST_ANSWER) begin
            // A write lands on the edge at which the master sees waitrequest
            // low, the one edge at which it is taken; nothing lands earlier.
            case (avs_address)
                `PCRF_OFF_PART_SEL: part_sel <= avs_writedata[8:0];
                `PCRF_OFF_CPBM: cpbm[ent] <= avs_writedata;
                `PCRF_OFF_CMAX: begin
                    cmax[ent] <= wfrac;
                    soft_lim[ent] <= avs_writedata[`PCRF_CMAX_SOFT_BIT];
                end
                `PCRF_OFF_MBW_PBM: mbw_pbm[ent] <= avs_writedata;
                `PCRF_OFF_MBW_MAX: begin
                    mbw_max[ent] <= wfrac;
                    hard_lim[ent] <= avs_writedata[`PCRF_MBW_HARD_BIT];
                end
                `PCRF_OFF_MBW_MIN: mbw_min[ent] <= wfrac;
                `PCRF_OFF_MBW_PROP: begin
                    prop_stride[ent] <= avs_writedata[15:0];
                    prop_en[ent] <= avs_writedata[`PCRF_PROP_EN_BIT];
                end
                `PCRF_OFF_CASSOC: cassoc[ent] <= wfrac;
                `PCRF_OFF_EN_FLAGS: en0[ent] <= avs_writedata[0];
                `PCRF_OFF_INTPART: int_map[ent] <= avs_writedata[3:0];
                `PCRF_OFF_WORK: work_sel <= avs_writedata[5:0];
                default: ;
            endcase
        end
    end

    // Handshake next state. A request seen while idle is answered on the
    // next cycle; the answer lasts exactly one cycle, after which the block
    // is idle again, so a back-to-back request costs two cycles.
    always @* begin
        next_hs_state = hs_state;
        case (hs_state)
            ST_IDLE: begin
                if (avs_read || avs_write) begin
                    next_hs_state = ST_ANSWER;
                end
            end
            ST_ANSWER: next_hs_state = ST_IDLE;
            default: next_hs_state = ST_IDLE;
        endcase
    end

    // Bus outputs come straight from flip-flops. Registering the answer
    // costs one wait cycle per access but keeps the read mux off the
    // output path.
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            hs_state <= ST_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
            avs_response_error <= 1'b0;
        end else begin
            hs_state <= next_hs_state;
            if (hs_state == ST_IDLE && (avs_read || avs_write)) begin
                avs_waitrequest <= 1'b0;
                avs_readdata <= avs_read ? next_rdata : 32'h00000000;
                avs_response_error <= next_err;
            end else begin
                avs_waitrequest <= 1'b1;
                avs_response_error <= 1'b0;
            end
        end
    end
endmodule

// *** bench/pcrf_bank_monitor.sv ***
// Concurrent checks on the bus port of the partition control bank.
`timescale 1ns/1ns
module pcrf_bank_monitor (
    input wire clock,
    input wire resetn,
    input wire [5:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire avs_response_error
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // Done marks the single answer cycle; frac marks the fraction registers.
    wire req = avs_read | avs_write;
    wire done = !avs_waitrequest;
    wire frac = avs_address == 6'h08 || avs_address == 6'h10 ||
        avs_address == 6'h14 || avs_address == 6'h1c;
    a_answer_next: assert property (req && !done |=> done)
        else $error("request not answered in the next cycle");
    a_done_single: assert property (done |=> !done)
        else $error("answer held longer than one cycle");
    a_idle_quiet: assert property (!req && !done |=> !done)
        else $error("answer without a request");
    a_err_unmapped: assert property (done && req && (avs_address > 6'h28 ||
        avs_address[1:0] != 2'b00) |-> avs_response_error)
        else $error("unmapped access not flagged");
    a_err_mapped: assert property (done && req && avs_address <= 6'h28 &&
        avs_address[1:0] == 2'b00 |-> !avs_response_error)
        else $error("mapped access flagged");
    a_err_no_data: assert property (avs_read && avs_response_error
        |-> avs_readdata == 32'h0) else $error("refused read not zero");
    a_frac_low_zero: assert property (
        done && avs_read && frac |-> avs_readdata[3:0] == 4'h0)
        else $error("dropped fraction bits not zero");
    a_work_range: assert property (
        done && avs_read && avs_address == 6'h28
        |-> avs_readdata[19:16] == 4'hf && avs_readdata[3:0] == 4'h0)
        else $error("working range ends wrong");
    c_write: cover property (done && avs_write);
    c_frac_read: cover property (done && avs_read && frac);
    c_refused: cover property (avs_response_error);
endmodule
bind pcrf_bank pcrf_bank_monitor i_mon (.clock(clock), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .avs_response_error(avs_response_error));

// *** bench/tb.sv ***
// Self-checking bench for the partition control bank.
`timescale 1ns/1ns
module tb;
    reg clock = 0, resetn = 0, avs_read = 0, avs_write = 0, er;
    reg [5:0] avs_address = 6'h00;
    reg [31:0] avs_writedata = 32'h0, rd, d;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, avs_response_error;
    int bad_count = 0, samples_checked = 0, seed = 66, i, s;
    logic [31:0] q[$];
    logic [5:0] ofs[8] = '{6'h04, 6'h08, 6'h0c, 6'h10, 6'h14, 6'h1c,
        6'h20, 6'h24};
    logic [31:0] dv[8] = '{32'hffffffff, 32'hfff0, 32'hffffffff, 32'hfff0,
        32'hfff0, 32'hfff0, 32'h1, 32'h0};
    logic [31:0] msk[8] = '{32'hffffffff, 32'h8000fff0, 32'hffffffff,
        32'h8000fff0, 32'hfff0, 32'hfff0, 32'h1, 32'hf};
    pcrf_bank i_dut (.clock(clock), .resetn(resetn),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .avs_response_error(avs_response_error));
    // Free-running 100 MHz clock.
    initial forever #5 clock = ~clock;
    // One bus access; the request is held until waitrequest is seen low.
    task acc(input bit w, input [5:0] a, input [31:0] wd);
        int n;
        @(posedge clock);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= wd;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        er = avs_response_error;
        if (n >= 50) bad_count++;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task chk(input [31:0] seen, input [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Defaults of the default partition in both spaces, working ends too.
    task dflt;
        for (s = 0; s < 2; s++) begin
            acc(1, 6'h00, s << 8);
            for (i = 0; i < 8; i++) begin
                acc(0, ofs[i], 32'h0);
                chk(rd, dv[i]);
            end
            acc(0, 6'h18, 32'h0);
            chk(rd, 32'h0);
            acc(1, 6'h28, s << 4);
            acc(0, 6'h28, 32'h0);
            chk(rd, 32'hfffffff0);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Long enough for every access several times over.
    initial begin
        #500000;
        bad_count++;
        tally_and_finish;
    end
    // Main sequence: defaults, random writes, refusal, fractions, reset.
    initial begin
        repeat (20) @(posedge clock);
        resetn <= 1'b1;
        dflt;
        acc(1, 6'h00, 32'h103);
        for (i = 0; i < 8; i++) begin
            d = $random(seed);
            acc(1, ofs[i], d);
            q.push_back(d & msk[i]);
        end
        for (i = 0; i < 8; i++) begin
            acc(0, ofs[i], 32'h0);
            chk(rd, q.pop_front());
        end
        acc(0, 6'h2c, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, er}, 32'h1);
        // A 50 percent maximum and 1 percent minimum on the default entry.
        acc(1, 6'h00, 32'h0);
        acc(1, 6'h10, 32'h7fff);
        acc(1, 6'h14, 32'h028e);
        acc(1, 6'h28, 32'h0);
        acc(0, 6'h28, 32'h0);
        chk(rd, 32'h7fff0280);
        acc(1, 6'h04, 32'h0);
        @(posedge clock);
        resetn <= 1'b0;
        @(posedge clock);
        resetn <= 1'b1;
        dflt;
        tally_and_finish;
    end
endmodule
